//--- hdl/cid_exec.sv
`timescale 1ns/1ps
// How it works
// RULE_01 - Clear-register spends Q1 decode, Q2 read, Q3 process and Q4 writes back to the same register.
// RULE_02 - Clear-accumulator loads zero into the accumulator and sets the zero flag, low seven bits ignored.
// RULE_03 - Clear-watchdog resets the watchdog counter to zero.
// RULE_04 - Clear-watchdog also zeroes the prescaler when it is assigned to the watchdog.
// RULE_05 - Clear-watchdog sets both the time-out and power-down status bits and touches no other flag.
// RULE_06 - Clear-watchdog is recognised by its fixed pattern with no operand fields.
// RULE_07 - Clear-watchdog is one word and completes in one instruction cycle.
// RULE_08 - Invert and decrement use a seven-bit register address and a one-bit destination selector.
// RULE_09 - Decrement-skip subtracts one from the register and writes the selected destination.
// RULE_10 - A zero decrement result discards the next instruction, otherwise the next one runs.
// RULE_11 - Clear-register writes zero into the register and sets the zero flag.
// RULE_12 - Destination zero writes the accumulator, destination one writes the file register.
// RULE_13 - A discarded instruction is replaced by a no-operation cycle, making two cycles.
// RULE_14 - Invert writes the complement to the destination and sets the zero flag from the result.
// RULE_15 - Decrement-skip changes no status flag.
module cid_exec (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Instruction fetch
  input wire logic [13:0] instr_word,
  output logic instr_take,
  // File register read port (data valid in Q3)
  output logic [6:0] file_addr,
  output logic file_rd,
  input wire logic [7:0] file_rdata,
  // File register write port
  output logic file_wr,
  output logic [7:0] file_wdata,
  // Watchdog side
  input wire logic prescaler_to_wdg,
  output logic wdg_clear,
  output logic prescaler_clear,
  output logic [7:0] watchdog_counter,
  // Core state
  output logic [7:0] accumulator_reg,
  output logic result_null_flag,
  output logic watchdog_expired_n,
  output logic sleep_entered_n,
  input wire logic status_set_expired_n,
  input wire logic status_set_sleep_n,
  output logic skip_active,
  output logic [1:0] phase
);
  import cid_pkg::*;

  // ==========================================
  // Decode helper
  function automatic cid_op_type cid_decode(input logic [13:0] w);
    cid_op_type op;
    op = CID_OP_NONE;
    if (w == CID_CLRWDG_PAT) begin
      op = CID_OP_CLRWDG; // RULE_06
    end else if ((w & CID_CLRREG_MASK) == CID_CLRREG_PAT) begin
      op = CID_OP_CLRREG;
    end else if ((w & CID_CLRACC_MASK) == CID_CLRACC_PAT) begin
      op = CID_OP_CLRACC; // RULE_02
    end else if ((w & CID_OPC_MASK) == CID_INVERT_PAT) begin
      op = CID_OP_INVERT;
    end else if ((w & CID_OPC_MASK) == CID_DECSKIP_PAT) begin
      op = CID_OP_DECSKIP;
    end
    return op;
  endfunction

  // ==========================================
  // Operand helper
  // Ops that fetch their operand from the file during Q2
  function automatic logic cid_reads_file(input cid_op_type op);
    return (op == CID_OP_INVERT) || (op == CID_OP_DECSKIP) || (op == CID_OP_CLRREG);
  endfunction

  // ==========================================
  // State
  typedef struct packed {
    cid_op_type op;
    logic [13:0] iw;
    logic [7:0] res;
    logic [7:0] acc;
    logic [7:0] wdg;
    logic zf;
    logic to_n;
    logic pd_n;
    logic skip;
    logic squash;
    logic wr;
    logic [7:0] wdata;
    logic wdg_clr;
    logic pre_clr;
  } cid_state_type;

  cid_state_type st_q;
  cid_state_type st_d;
  cid_phase_if ph ();

  cid_phase_gen u_phase (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ph(ph)
  );

  logic dest_is_file;
  logic [7:0] dec_val;
  assign dest_is_file = st_q.iw[CID_DEST_BIT]; // RULE_12
  assign dec_val = file_rdata - CID_ONE_BYTE;

  // ==========================================
  // Per-phase execution
  always_comb begin
    st_d = st_q;
    st_d.wr = 1'b0;
    st_d.wdg_clr = 1'b0;
    st_d.pre_clr = 1'b0;
    // Stand-in watchdog count, one step per instruction cycle; the real
    // timer runs from its own oscillator, so this is only an approximation
    if (ph.cycle_end) begin
      st_d.wdg = st_q.wdg + CID_ONE_BYTE;
    end
    // Later assignments below win, so a clear beats the step
    case (ph.phase)
      CID_Q1: begin
        // Decode; a squashed slot executes as a no-operation
        st_d.iw = instr_word;
        st_d.op = st_q.skip ? CID_OP_NONE : cid_decode(instr_word); // RULE_13
        st_d.squash = st_q.skip;
        st_d.skip = 1'b0;
      end
      CID_Q2: begin
        // Read happens here; data is sampled at Q3
      end
      CID_Q3: begin
        case (st_q.op)
          CID_OP_CLRREG: st_d.res = CID_ZERO_BYTE; // RULE_01
          CID_OP_CLRACC: st_d.res = CID_ZERO_BYTE;
          CID_OP_INVERT: st_d.res = ~file_rdata; // RULE_14
          CID_OP_DECSKIP: st_d.res = dec_val; // RULE_09
          default: st_d.res = st_q.res;
        endcase
      end
      CID_Q4: begin
        case (st_q.op)
          CID_OP_CLRREG: begin
            st_d.wr = 1'b1; // RULE_01
            st_d.wdata = CID_ZERO_BYTE; // RULE_11
            st_d.zf = 1'b1; // RULE_11
          end
          CID_OP_CLRACC: begin
            st_d.acc = CID_ZERO_BYTE; // RULE_02
            st_d.zf = 1'b1; // RULE_02
          end
          CID_OP_CLRWDG: begin
            st_d.wdg = CID_ZERO_BYTE; // RULE_03
            st_d.wdg_clr = 1'b1; // RULE_07
            st_d.pre_clr = prescaler_to_wdg; // RULE_04
            st_d.to_n = 1'b1; // RULE_05
            st_d.pd_n = 1'b1; // RULE_05
          end
          CID_OP_INVERT: begin
            if (dest_is_file) begin
              st_d.wr = 1'b1; // RULE_12
              st_d.wdata = st_q.res;
            end else begin
              st_d.acc = st_q.res; // RULE_12
            end
            st_d.zf = (st_q.res == CID_ZERO_BYTE); // RULE_14
          end
          CID_OP_DECSKIP: begin
            if (dest_is_file) begin
              st_d.wr = 1'b1; // RULE_12
              st_d.wdata = st_q.res;
            end else begin
              st_d.acc = st_q.res;
            end
            st_d.skip = (st_q.res == CID_ZERO_BYTE); // RULE_10
            // Flags left alone on purpose RULE_15
          end
          default: begin
          end
        endcase
        // External status writers apply only when this op does not own them
        if (st_q.op != CID_OP_CLRWDG) begin
          if (status_set_expired_n) begin
            st_d.to_n = 1'b0;
          end
          if (status_set_sleep_n) begin
            st_d.pd_n = 1'b0;
          end
        end
      end
      default: begin
      end
    endcase
  end

  // ==========================================
  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q.op <= CID_OP_NONE;
      st_q.iw <= 14'h0000;
      st_q.res <= CID_ZERO_BYTE;
      st_q.acc <= CID_ACC_RESET;
      st_q.wdg <= CID_ZERO_BYTE;
      st_q.zf <= 1'b0;
      st_q.to_n <= 1'b1;
      st_q.pd_n <= 1'b1;
      st_q.skip <= 1'b0;
      st_q.squash <= 1'b0;
      st_q.wr <= 1'b0;
      st_q.wdata <= CID_ZERO_BYTE;
      st_q.wdg_clr <= 1'b0;
      st_q.pre_clr <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================
  // Outputs
  assign instr_take = (ph.phase == CID_Q1);
  assign file_addr = st_q.iw[CID_FADDR_MSB:0]; // RULE_08
  assign file_rd = (ph.phase == CID_Q2) && cid_reads_file(st_q.op); // RULE_01
  assign file_wr = st_q.wr;
  assign file_wdata = st_q.wdata;
  assign wdg_clear = st_q.wdg_clr;
  assign prescaler_clear = st_q.pre_clr;
  assign watchdog_counter = st_q.wdg;
  assign accumulator_reg = st_q.acc;
  assign result_null_flag = st_q.zf;
  assign watchdog_expired_n = st_q.to_n;
  assign sleep_entered_n = st_q.pd_n;
  assign skip_active = st_q.squash;
  assign phase = ph.phase;
endmodule

//--- hdl/cid_pkg.sv
package cid_pkg;
  // ==========================================
  // Opcode patterns (14-bit words)
  localparam logic [13:0] CID_CLRREG_MASK = 14'h3f80;
  localparam logic [13:0] CID_CLRREG_PAT = 14'h0180;
  localparam logic [13:0] CID_CLRACC_MASK = 14'h3f80;
  localparam logic [13:0] CID_CLRACC_PAT = 14'h0100;
  localparam logic [13:0] CID_CLRWDG_PAT = 14'h0064;
  localparam logic [13:0] CID_OPC_MASK = 14'h3f00;
  localparam logic [13:0] CID_INVERT_PAT = 14'h0900;
  localparam logic [13:0] CID_DECSKIP_PAT = 14'h0b00;
  // ==========================================
  // Field positions
  localparam int CID_DEST_BIT = 7;
  localparam int CID_FADDR_MSB = 6;
  // ==========================================
  // Reset values and byte constants
  localparam logic [7:0] CID_ACC_RESET = 8'h00;
  localparam logic [7:0] CID_ZERO_BYTE = 8'h00;
  localparam logic [7:0] CID_ONE_BYTE = 8'h01;
  localparam logic [1:0] CID_Q_RESET = 2'h0;

  // Quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    CID_Q1 = 2'b00,
    CID_Q2 = 2'b01,
    CID_Q3 = 2'b10,
    CID_Q4 = 2'b11
  } cid_phase_type;

  // Decoded operation
  typedef enum logic [2:0] {
    CID_OP_NONE = 3'b000,
    CID_OP_CLRREG = 3'b001,
    CID_OP_CLRACC = 3'b010,
    CID_OP_CLRWDG = 3'b011,
    CID_OP_INVERT = 3'b100,
    CID_OP_DECSKIP = 3'b101
  } cid_op_type;
endpackage

//--- hdl/cid_file_if.sv
`timescale 1ns/1ps
// ==========================================
// Quarter phase bundle from the sequencer to the executor
interface cid_phase_if;
  logic [1:0] phase;
  logic cycle_end;
  modport src (output phase, output cycle_end);
  modport dst (input phase, input cycle_end);
endinterface

//--- hdl/cid_phase_gen.sv
`timescale 1ns/1ps
// ==========================================
// Quarter-phase sequencer: Q1..Q4 repeating, one per mclk
module cid_phase_gen (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Phase outputs
  cid_phase_if.src ph
);
  import cid_pkg::*;

  typedef struct packed {
    logic [1:0] q;
  } cid_pg_state_type;

  cid_pg_state_type st_q;
  cid_pg_state_type st_d;

  // Next phase wraps after Q4
  always_comb begin
    st_d = st_q;
    st_d.q = st_q.q + 2'h1;
  end

  // Phase register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q.q <= CID_Q_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign ph.phase = st_q.q;
  assign ph.cycle_end = (st_q.q == CID_Q4);
endmodule

//--- bench/cid_exec_chk.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the executor
module cid_exec_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Driven into the core
  input wire logic [13:0] instr_word,
  input wire logic [7:0] file_rdata,
  input wire logic prescaler_to_wdg,
  // Driven by the core
  input wire logic file_wr,
  input wire logic [7:0] file_wdata,
  input wire logic wdg_clear,
  input wire logic prescaler_clear,
  input wire logic [7:0] watchdog_counter,
  input wire logic [7:0] accumulator_reg,
  input wire logic result_null_flag,
  input wire logic watchdog_expired_n,
  input wire logic sleep_entered_n,
  input wire logic skip_active,
  input wire logic [1:0] phase
);
  logic [13:0] iw_q;
  logic [7:0] rd_q;
  logic sk_q;
  // Result cycle of a word that really ran, not a squashed one
  wire live = phase == 2'h0 && !sk_q;
  wire clr_reg = (iw_q & 14'h3f80) == 14'h0180;
  wire clr_acc = (iw_q & 14'h3f80) == 14'h0100;
  wire inv = (iw_q & 14'h3f00) == 14'h0900;
  wire dec = (iw_q & 14'h3f00) == 14'h0b00;
  // Keep word and operand so each result can be tied to its cause
  always_ff @(posedge mclk) begin
    iw_q <= sys_rst ? 14'h0000 : (phase == 2'h0 ? instr_word : iw_q);
    rd_q <= phase == 2'h2 ? file_rdata : rd_q;
    sk_q <= sys_rst ? 1'b0 : skip_active;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Skip the first edge after release: the phase was still held there
  property p_phase; !$past(sys_rst) |-> phase == $past(phase) + 2'h1; endproperty
  property p_wr; file_wr |-> phase == 2'h0; endproperty
  property p_clr; live && clr_reg |-> file_wr && file_wdata == 8'h00 && result_null_flag; endproperty
  property p_acc; live && clr_acc |-> accumulator_reg == 8'h00 && result_null_flag; endproperty
  property p_wdg; live && iw_q == 14'h0064 |-> wdg_clear && watchdog_counter == 8'h00; endproperty
  property p_stat; live && iw_q == 14'h0064 |-> watchdog_expired_n && sleep_entered_n; endproperty
  property p_pre; live && iw_q == 14'h0064 && $past(prescaler_to_wdg) |-> prescaler_clear; endproperty
  property p_dec; live && dec && iw_q[7] |-> file_wr && file_wdata == rd_q - 8'h01; endproperty
  property p_inv; live && inv && !iw_q[7] |-> accumulator_reg == ~rd_q && result_null_flag == (rd_q == 8'hff); endproperty
  property p_skip; live && dec && rd_q == 8'h01 |=> skip_active [*3]; endproperty
  property p_keep; live && dec |-> $stable(result_null_flag); endproperty
  a_phase: assert property (p_phase) else $error("phase did not advance");
  a_wr: assert property (p_wr) else $error("write outside first quarter");
  a_clr: assert property (p_clr) else $error("clear register result wrong");
  a_acc: assert property (p_acc) else $error("clear accumulator result wrong");
  a_wdg: assert property (p_wdg) else $error("watchdog not cleared");
  a_stat: assert property (p_stat) else $error("status bits not set");
  a_pre: assert property (p_pre) else $error("prescaler not cleared");
  a_dec: assert property (p_dec) else $error("decrement result wrong");
  a_inv: assert property (p_inv) else $error("invert result wrong");
  a_skip: assert property (p_skip) else $error("skip cycle missing");
  a_keep: assert property (p_keep) else $error("decrement touched flag");
  c_skip: cover property (live && dec && rd_q == 8'h01);
  c_pre: cover property (live && iw_q == 14'h0064 && prescaler_clear);
  c_inv: cover property (live && inv && result_null_flag);
endmodule

//--- bench/clear_invert_decrement_ops_test.sv
`timescale 1ns/1ps
// ==========================================
// Bench: bench plays the fetch unit, file registers and watchdog
module clear_invert_decrement_ops_test;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] file_rdata = 8'h00;
  logic prescaler_to_wdg = 1'b0;
  logic status_set_expired_n = 1'b0;
  logic status_set_sleep_n = 1'b0;
  logic instr_take, file_rd, file_wr, wdg_clear, prescaler_clear, result_null_flag;
  logic watchdog_expired_n, sleep_entered_n, skip_active;
  logic [6:0] file_addr;
  logic [7:0] file_wdata, watchdog_counter, accumulator_reg;
  logic [1:0] phase;
  logic [7:0] mem [128];
  int err_count = 0;
  int checked = 0;
  int wdg_hits = 0;
  int pre_hits = 0;
  cid_exec uut (.mclk, .sys_rst, .instr_word, .instr_take, .file_addr, .file_rd, .file_rdata, .file_wr,
    .file_wdata, .prescaler_to_wdg, .wdg_clear, .prescaler_clear, .watchdog_counter, .accumulator_reg,
    .result_null_flag, .watchdog_expired_n, .sleep_entered_n, .status_set_expired_n, .status_set_sleep_n,
    .skip_active, .phase);
  always #50 mclk = ~mclk;
  // File model: data only after a read strobe, else a toggling pattern so stale bytes never pass
  always @(posedge mclk) begin
    file_rdata <= file_rd ? mem[file_addr] : ~file_rdata;
    if (file_wr) mem[file_addr] <= file_wdata;
    if (wdg_clear) wdg_hits <= wdg_hits + 1;
    if (prescaler_clear) pre_hits <= pre_hits + 1;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Word goes up as Q1 starts, so it is stable when taken
  task automatic run(input logic [13:0] w);
    while (phase !== 2'h3) @(negedge mclk);
    @(posedge mclk) instr_word <= w;
    @(negedge mclk);
    chk({7'h00, instr_take}, 8'h01);
  endtask
  // One idle word, then past the write edge
  task automatic settle;
    run(14'h0000);
    @(negedge mclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic t_clear;
    mem[7'h05] = 8'h5a;
    mem[7'h7f] = 8'h33;
    run(14'h0185);
    run(14'h01ff);
    settle;
    chk(mem[7'h05], 8'h00);
    chk(mem[7'h7f], 8'h00);
    chk({7'h00, result_null_flag}, 8'h01);
    $display("done: clear register");
  endtask
  task automatic t_invert;
    mem[7'h09] = 8'h5a;
    mem[7'h7f] = 8'hff;
    run(14'h0989);
    run(14'h097f);
    settle;
    chk(mem[7'h09], 8'ha5);
    chk(mem[7'h7f], 8'hff);
    chk(accumulator_reg, 8'h00);
    chk({7'h00, result_null_flag}, 8'h01);
    $display("done: invert");
  endtask
  task automatic t_decrement;
    mem[7'h14] = 8'h02;
    run(14'h0909);
    run(14'h0b94);
    run(14'h017f);
    settle;
    chk(accumulator_reg, 8'h00);
    chk(mem[7'h14], 8'h01);
    run(14'h0909);
    run(14'h0b14);
    run(14'h017f);
    settle;
    chk({7'h00, result_null_flag}, 8'h00);
    chk(accumulator_reg, 8'h00);
    chk(mem[7'h14], 8'h01);
    $display("done: decrement and skip");
  endtask
  task automatic t_watchdog;
    @(posedge mclk) status_set_expired_n <= 1'b1;
    status_set_sleep_n <= 1'b1;
    settle;
    chk({6'h00, watchdog_expired_n, sleep_entered_n}, 8'h00);
    @(posedge mclk) status_set_expired_n <= 1'b0;
    status_set_sleep_n <= 1'b0;
    prescaler_to_wdg <= 1'b1;
    run(14'h0064);
    settle;
    chk({6'h00, watchdog_expired_n, sleep_entered_n}, 8'h03);
    chk({7'h00, result_null_flag}, 8'h00);
    chk(watchdog_counter, 8'h00);
    chk(8'(pre_hits), 8'h01);
    @(posedge mclk) prescaler_to_wdg <= 1'b0;
    run(14'h0064);
    run(14'h0065);
    settle;
    chk(8'(wdg_hits), 8'h02);
    chk(watchdog_counter, 8'h01);
    chk(8'(pre_hits), 8'h01);
    $display("done: watchdog clear");
  endtask
  // Hang guard: whole run needs well under 300 cycles
  initial begin
    #100000;
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    chk({6'h00, watchdog_expired_n, sleep_entered_n}, 8'h03);
    chk(accumulator_reg, 8'h00);
    t_clear;
    t_invert;
    t_decrement;
    t_watchdog;
    wrap_up;
  end
endmodule
bind cid_exec cid_exec_chk chk (.mclk, .sys_rst, .instr_word, .file_rdata, .prescaler_to_wdg, .file_wr,
  .file_wdata, .wdg_clear, .prescaler_clear, .watchdog_counter, .accumulator_reg, .result_null_flag,
  .watchdog_expired_n, .sleep_entered_n, .skip_active, .phase);
